// *** include/twm_pkg.sv ***
// Contract
// [R1] writing one to the done flag clears it
// [R2] no new bus operation starts while the done flag stays set
// [R3] clearing the flag with start pending begins START at once
// [R4] after START: set done flag, post start-sent code
// [R5] after address byte: set done flag, post address-sent code
// [R6] address and data codes tell acknowledge from not-acknowledge
// [R7] after data byte: set done flag, post data-sent code
// [R8] after STOP: flag stays clear, no completion event
// [R9] serial clock held low while flag set and awaiting software
// [R10] one data register carries both address byte and data bytes
// [R11] software loads address with write bit before commanding transmission
// [R12] software loads next data byte before commanding its transmission
// [R13] software updates registers first, then writes control with flag bit
// [R14] control write with flag bit runs the operation its command bits select
// [R15] software masks status with f8 before comparing codes
// [R16] software checks each code and branches to error handling on mismatch
// [R17] START only on free bus, else wait for STOP first
// [R18] stop request makes STOP, then its bit clears by itself
// [R19] status: code in bits 7..3, reserved bit 2 zero, prescaler 1..0
`default_nettype none
package twm_pkg;
  localparam int unsigned DW = 8;
  localparam int unsigned CMD_W = 11;
  localparam int unsigned BUF_DEPTH = 2;
  // ****************************************
  // command operations
  // ****************************************
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_START = 2'h1;
  localparam logic [1:0] OP_BYTE = 2'h3;
  localparam logic [1:0] OP_STOP = 2'h2;
  // command word field positions
  localparam int unsigned CMD_OP_HI = 10;
  localparam int unsigned CMD_OP_LO = 9;
  localparam int unsigned CMD_BYTE_HI = 8;
  localparam int unsigned CMD_BYTE_LO = 1;
  localparam int unsigned CMD_ADDR = 0;
  // ****************************************
  // status codes, upper five bits
  // ****************************************
  localparam logic [4:0] SC_START = 5'h01;
  localparam logic [4:0] SC_RSTART = 5'h02;
  localparam logic [4:0] SC_ADDR_ACK = 5'h03;
  localparam logic [4:0] SC_ADDR_NACK = 5'h04;
  localparam logic [4:0] SC_DATA_ACK = 5'h05;
  localparam logic [4:0] SC_DATA_NACK = 5'h06;
  localparam logic [4:0] SC_NO_INFO = 5'h1f;
  localparam logic [7:0] STATUS_MASK = 8'hf8;
  localparam logic [7:0] DATA_RST = 8'hff;
  localparam logic [1:0] PRESC_RST = 2'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // ****************************************
  // link engine states
  // ****************************************
  typedef enum logic [3:0] {
    LS_IDLE = 4'h0,
    LS_WAIT_FREE = 4'h1,
    LS_START_A = 4'h3,
    LS_START_B = 4'h2,
    LS_HOLD = 4'h6,
    LS_BIT_LOW = 4'h7,
    LS_BIT_HIGH = 4'h5,
    LS_ACK_LOW = 4'h4,
    LS_ACK_HIGH = 4'hc,
    LS_ACK_FALL = 4'hd,
    LS_STOP_A = 4'hf,
    LS_STOP_B = 4'he,
    LS_STOP_C = 4'ha,
    LS_RS_A = 4'hb,
    LS_RS_B = 4'h9
  } twm_lst_t;

  function automatic logic [4:0] ack_code(input logic is_addr, input logic nack);
    if (is_addr)
      ack_code = nack ? SC_ADDR_NACK : SC_ADDR_ACK;
    else
      ack_code = nack ? SC_DATA_NACK : SC_DATA_ACK;
  endfunction : ack_code
endpackage : twm_pkg
`default_nettype wire

// *** src/twm_cmd_buf.sv ***
`timescale 1ns/1ns
`default_nettype none
module twm_cmd_buf
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [twm_pkg::CMD_W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [twm_pkg::CMD_W-1:0] out_data_o
);
  import twm_pkg::*;

  logic [CMD_W-1:0] mem_ff [BUF_DEPTH];
  logic wr_ptr_ff;
  logic rd_ptr_ff;
  logic [1:0] cnt_ff;
  logic rdy_ff;
  logic [1:0] nxt_cnt;
  wire push = in_valid_i & rdy_ff;
  wire pop = out_valid_o & out_ready_i;

  assign nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
  assign in_ready_o = rdy_ff;
  assign out_valid_o = (cnt_ff != 2'h0);
  assign out_data_o = mem_ff[rd_ptr_ff];

  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_ff[wr_ptr_ff] <= in_data_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      cnt_ff <= 2'h0;
      rdy_ff <= 1'b1;
    end
    else
    begin
      wr_ptr_ff <= wr_ptr_ff ^ push;
      rd_ptr_ff <= rd_ptr_ff ^ pop;
      cnt_ff <= nxt_cnt;
      rdy_ff <= (nxt_cnt != 2'(BUF_DEPTH));
    end
  end
endmodule : twm_cmd_buf
`default_nettype wire

// *** src/twm_master_tx.sv ***
`timescale 1ns/1ns
`default_nettype none
module twm_master_tx
(
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic CTRL_WR_I,
  input wire logic CTRL_FLAG_I,
  input wire logic CTRL_START_I,
  input wire logic CTRL_STOP_I,
  input wire logic CTRL_EN_I,
  output logic CTRL_READY_O,
  input wire logic DATA_WR_I,
  input wire logic [twm_pkg::DW-1:0] DATA_I,
  input wire logic PRESC_WR_I,
  input wire logic [1:0] PRESC_I,
  output logic DONE_FLAG_O,
  output logic START_REQ_O,
  output logic STOP_REQ_O,
  output logic [twm_pkg::DW-1:0] STATUS_O,
  output logic [twm_pkg::DW-1:0] DATA_O,
  input wire logic LINK_CLK_I,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE_O,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O
);
  import twm_pkg::*;

  // ****************************************
  // system side registers
  // ****************************************
  logic flag_ff;
  logic start_ff;
  logic stop_req_ff;
  logic [DW-1:0] data_ff;
  logic [4:0] code_ff;
  logic [1:0] presc_ff;
  logic [DW-1:0] status_ff;
  logic addr_next_ff;
  logic inflight_ff;
  logic req_tgl_ff;
  logic [CMD_W-1:0] cmd_hold_ff;
  logic dn_s1_ff;
  logic dn_s2_ff;
  logic dn_s3_ff;
  logic dn_tgl_ff;
  logic buf_in_rdy;
  logic buf_out_vld;
  logic [CMD_W-1:0] buf_out_data;

  wire clr_wr = CTRL_WR_I & CTRL_FLAG_I;
  wire launch = clr_wr & CTRL_EN_I & buf_in_rdy; // [R2]
  wire [1:0] sel_op = CTRL_START_I ? OP_START :
                      CTRL_STOP_I ? OP_STOP :
                      flag_ff ? OP_BYTE : OP_NONE;
  wire push = launch & (sel_op != OP_NONE);
  wire [CMD_W-1:0] push_word = {sel_op, data_ff, addr_next_ff};
  wire pop = buf_out_vld & ~inflight_ff;
  wire done_evt = dn_s2_ff ^ dn_s3_ff;
  wire [1:0] cur_op = cmd_hold_ff[CMD_OP_HI:CMD_OP_LO];
  wire done_stop = done_evt & (cur_op == OP_STOP);
  wire done_flag = done_evt & ~done_stop;
  logic [4:0] lnk_code_ff;
  wire [4:0] nxt_code = done_stop ? SC_NO_INFO : done_evt ? lnk_code_ff : code_ff;
  wire [1:0] nxt_presc = PRESC_WR_I ? PRESC_I : presc_ff;
  wire nxt_flag = done_flag | (flag_ff & ~clr_wr);
  wire nxt_stop_req = (CTRL_WR_I & CTRL_STOP_I) | (stop_req_ff & ~done_stop);
  wire done_is_start = done_flag & (cur_op == OP_START);
  wire done_is_byte = done_flag & (cur_op == OP_BYTE);
  wire data_wr_ok = DATA_WR_I & ~inflight_ff;

  twm_cmd_buf u_buf
  (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .in_valid_i(push),
    .in_ready_o(buf_in_rdy),
    .in_data_i(push_word),
    .out_valid_o(buf_out_vld),
    .out_ready_i(~inflight_ff),
    .out_data_o(buf_out_data)
  );

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      flag_ff <= 1'b0;
      start_ff <= 1'b0;
      stop_req_ff <= 1'b0;
      data_ff <= DATA_RST;
      code_ff <= SC_NO_INFO;
      presc_ff <= PRESC_RST;
      status_ff <= {SC_NO_INFO, 1'b0, PRESC_RST};
      addr_next_ff <= 1'b0;
      inflight_ff <= 1'b0;
      req_tgl_ff <= 1'b0;
      cmd_hold_ff <= '0;
    end
    else
    begin
      flag_ff <= nxt_flag; // [R1] [R4] [R5] [R7]
      if (CTRL_WR_I)
        start_ff <= CTRL_START_I;
      stop_req_ff <= nxt_stop_req; // [R18]
      if (data_wr_ok)
        data_ff <= DATA_I; // [R10]
      code_ff <= nxt_code;
      presc_ff <= nxt_presc;
      status_ff <= {nxt_code, 1'b0, nxt_presc}; // [R19]
      if (done_is_start)
        addr_next_ff <= 1'b1;
      else if (done_is_byte)
        addr_next_ff <= 1'b0;
      inflight_ff <= pop | (inflight_ff & ~done_evt);
      if (pop)
      begin
        cmd_hold_ff <= buf_out_data; // [R14]
        req_tgl_ff <= ~req_tgl_ff;
      end
    end
  end

  // done toggle from link domain
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      dn_s1_ff <= 1'b0;
      dn_s2_ff <= 1'b0;
      dn_s3_ff <= 1'b0;
    end
    else
    begin
      dn_s1_ff <= dn_tgl_ff;
      dn_s2_ff <= dn_s1_ff;
      dn_s3_ff <= dn_s2_ff;
    end
  end

  assign DONE_FLAG_O = flag_ff;
  assign START_REQ_O = start_ff;
  assign STOP_REQ_O = stop_req_ff;
  assign STATUS_O = status_ff;
  assign DATA_O = data_ff;
  assign CTRL_READY_O = buf_in_rdy;

  // ****************************************
  // link side engine
  // ****************************************
  logic lrst_s1_ff;
  logic lrst_ff;
  logic rq_s1_ff;
  logic rq_s2_ff;
  logic rq_s3_ff;
  logic scl_s1_ff;
  logic scl_s2_ff;
  logic sda_s1_ff;
  logic sda_s2_ff;
  logic sda_d_ff;
  logic bus_busy_ff;
  twm_lst_t lst_ff;
  twm_lst_t nxt_lst;
  logic [2:0] bitcnt_ff;
  logic [2:0] nxt_bitcnt;
  logic [DW-1:0] shf_ff;
  logic [DW-1:0] nxt_shf;
  logic scl_oe_ff;
  logic nxt_scl_oe;
  logic sda_oe_ff;
  logic nxt_sda_oe;
  logic nack_ff;
  logic nxt_nack;
  logic rs_ff;
  logic nxt_rs;
  logic [4:0] nxt_lnk_code;
  logic nxt_dn_tgl;
  logic scl_o_ff;
  logic sda_o_ff;

  wire cmd_new = rq_s2_ff ^ rq_s3_ff;
  wire [1:0] lnk_op = cmd_hold_ff[CMD_OP_HI:CMD_OP_LO];
  wire lnk_addr = cmd_hold_ff[CMD_ADDR];
  wire bus_start_seen = scl_s2_ff & sda_d_ff & ~sda_s2_ff;
  wire bus_stop_seen = scl_s2_ff & ~sda_d_ff & sda_s2_ff;

  always_comb
  begin
    nxt_lst = lst_ff;
    nxt_bitcnt = bitcnt_ff;
    nxt_shf = shf_ff;
    nxt_scl_oe = scl_oe_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_nack = nack_ff;
    nxt_rs = rs_ff;
    nxt_lnk_code = lnk_code_ff;
    nxt_dn_tgl = dn_tgl_ff;
    case (lst_ff)
      LS_IDLE:
      begin
        nxt_scl_oe = 1'b0;
        nxt_sda_oe = 1'b0;
        nxt_rs = 1'b0;
        if (cmd_new)
        begin
          if (lnk_op == OP_START)
            nxt_lst = bus_busy_ff ? LS_WAIT_FREE : LS_START_A; // [R3] [R17]
          else
          begin
            nxt_lnk_code = SC_NO_INFO;
            nxt_dn_tgl = ~dn_tgl_ff;
          end
        end
      end
      LS_WAIT_FREE:
        if (!bus_busy_ff)
          nxt_lst = LS_START_A; // [R17]
      LS_START_A:
      begin
        nxt_sda_oe = 1'b1;
        nxt_lst = LS_START_B;
      end
      LS_START_B:
      begin
        nxt_scl_oe = 1'b1;
        nxt_lnk_code = rs_ff ? SC_RSTART : SC_START; // [R4]
        nxt_dn_tgl = ~dn_tgl_ff;
        nxt_lst = LS_HOLD;
      end
      LS_HOLD:
      begin
        nxt_scl_oe = 1'b1; // [R9]
        if (cmd_new)
        begin
          case (lnk_op)
            OP_START: nxt_lst = LS_RS_A;
            OP_STOP: nxt_lst = LS_STOP_A;
            OP_BYTE:
            begin
              nxt_shf = cmd_hold_ff[CMD_BYTE_HI:CMD_BYTE_LO]; // [R10]
              nxt_bitcnt = 3'h0;
              nxt_lst = LS_BIT_LOW;
            end
            default:
            begin
              nxt_lnk_code = SC_NO_INFO;
              nxt_dn_tgl = ~dn_tgl_ff;
            end
          endcase
        end
      end
      // data moves while clock held low; wait until synchronised clock shows low
      LS_BIT_LOW:
      begin
        nxt_sda_oe = ~shf_ff[DW-1];
        nxt_scl_oe = 1'b1;
        if (!scl_s2_ff)
          nxt_lst = LS_BIT_HIGH;
      end
      LS_BIT_HIGH:
      begin
        nxt_scl_oe = 1'b0;
        if (scl_s2_ff)
        begin
          nxt_scl_oe = 1'b1;
          nxt_shf = {shf_ff[DW-2:0], 1'b0};
          nxt_bitcnt = 3'(bitcnt_ff + 3'h1);
          nxt_lst = (bitcnt_ff == BIT_LAST) ? LS_ACK_LOW : LS_BIT_LOW;
        end
      end
      LS_ACK_LOW:
      begin
        nxt_sda_oe = 1'b0;
        nxt_scl_oe = 1'b1;
        if (!scl_s2_ff)
          nxt_lst = LS_ACK_HIGH;
      end
      LS_ACK_HIGH:
      begin
        nxt_scl_oe = 1'b0;
        if (scl_s2_ff)
        begin
          nxt_nack = sda_s2_ff;
          nxt_scl_oe = 1'b1;
          nxt_lst = LS_ACK_FALL;
        end
      end
      LS_ACK_FALL:
      begin
        nxt_lnk_code = ack_code(lnk_addr, nack_ff); // [R5] [R6] [R7]
        nxt_dn_tgl = ~dn_tgl_ff;
        nxt_lst = LS_HOLD;
      end
      LS_STOP_A:
      begin
        nxt_sda_oe = 1'b1;
        nxt_lst = LS_STOP_B;
      end
      LS_STOP_B:
      begin
        nxt_scl_oe = 1'b0;
        nxt_lst = LS_STOP_C;
      end
      LS_STOP_C:
        if (scl_s2_ff)
        begin
          nxt_sda_oe = 1'b0;
          nxt_lnk_code = SC_NO_INFO; // [R8] [R18]
          nxt_dn_tgl = ~dn_tgl_ff;
          nxt_lst = LS_IDLE;
        end
      LS_RS_A:
      begin
        nxt_sda_oe = 1'b0;
        nxt_lst = LS_RS_B;
      end
      LS_RS_B:
      begin
        nxt_scl_oe = 1'b0;
        nxt_rs = 1'b1;
        if (scl_s2_ff)
          nxt_lst = LS_START_A;
      end
      default: nxt_lst = LS_IDLE;
    endcase
  end

  // reset, request toggle and bus pins into link domain
  always_ff @(posedge LINK_CLK_I)
  begin
    lrst_s1_ff <= SYS_RST_I;
    lrst_ff <= lrst_s1_ff;
    rq_s1_ff <= req_tgl_ff;
    rq_s2_ff <= rq_s1_ff;
    scl_s1_ff <= SCL_I;
    scl_s2_ff <= scl_s1_ff;
    sda_s1_ff <= SDA_I;
    sda_s2_ff <= sda_s1_ff;
    sda_d_ff <= sda_s2_ff;
  end

  always_ff @(posedge LINK_CLK_I)
  begin
    if (lrst_ff)
    begin
      lst_ff <= LS_IDLE;
      bitcnt_ff <= 3'h0;
      shf_ff <= '0;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      nack_ff <= 1'b0;
      rs_ff <= 1'b0;
      lnk_code_ff <= SC_NO_INFO;
      dn_tgl_ff <= 1'b0;
      rq_s3_ff <= 1'b0;
      bus_busy_ff <= 1'b0;
      scl_o_ff <= 1'b0;
      sda_o_ff <= 1'b0;
    end
    else
    begin
      lst_ff <= nxt_lst;
      bitcnt_ff <= nxt_bitcnt;
      shf_ff <= nxt_shf;
      scl_oe_ff <= nxt_scl_oe;
      sda_oe_ff <= nxt_sda_oe;
      nack_ff <= nxt_nack;
      rs_ff <= nxt_rs;
      lnk_code_ff <= nxt_lnk_code;
      dn_tgl_ff <= nxt_dn_tgl;
      rq_s3_ff <= rq_s2_ff;
      bus_busy_ff <= bus_start_seen | (bus_busy_ff & ~bus_stop_seen); // [R17]
      scl_o_ff <= 1'b0;
      sda_o_ff <= 1'b0;
    end
  end

  assign SCL_O = scl_o_ff;
  assign SCL_OE_O = scl_oe_ff;
  assign SDA_O = sda_o_ff;
  assign SDA_OE_O = sda_oe_ff;

  // ****************************************
  // checks
  // ****************************************
  property p_flag_clear;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    flag_ff && clr_wr && !done_flag |=> !flag_ff;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by write"); // [R1]

  property p_no_op_while_flag;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    flag_ff |-> !pop && !inflight_ff;
  endproperty
  a_no_op_while_flag: assert property (p_no_op_while_flag) else $error("op while flag"); // [R2]

  property p_start_begins;
    @(posedge LINK_CLK_I) disable iff (lrst_ff)
    (lst_ff == LS_IDLE) && cmd_new && (lnk_op == OP_START) && !bus_busy_ff
      |=> (lst_ff == LS_START_A) ##1 (lst_ff == LS_START_B);
  endproperty
  a_start_begins: assert property (p_start_begins) else $error("start not begun"); // [R3]

  property p_start_code;
    @(posedge LINK_CLK_I) disable iff (lrst_ff)
    (lst_ff == LS_START_B) && !rs_ff |=> (lnk_code_ff == SC_START) && $changed(dn_tgl_ff);
  endproperty
  a_start_code: assert property (p_start_code) else $error("start code missing"); // [R4]

  property p_byte_code;
    @(posedge LINK_CLK_I) disable iff (lrst_ff)
    (lst_ff == LS_ACK_FALL)
      |=> (lnk_code_ff == ack_code($past(lnk_addr), $past(nack_ff))) && (lst_ff == LS_HOLD);
  endproperty
  a_byte_code: assert property (p_byte_code) else $error("byte code wrong"); // [R6]

  property p_stop_no_flag;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    done_stop && !flag_ff |=> !flag_ff && !stop_req_ff && (code_ff == SC_NO_INFO);
  endproperty
  a_stop_no_flag: assert property (p_stop_no_flag) else $error("flag after stop"); // [R8]

  property p_hold_scl;
    @(posedge LINK_CLK_I) disable iff (lrst_ff)
    (lst_ff == LS_HOLD) && $past(lst_ff == LS_HOLD) |-> scl_oe_ff;
  endproperty
  a_hold_scl: assert property (p_hold_scl) else $error("clock released in hold"); // [R9]

  property p_done_sets_flag;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    done_flag |=> flag_ff && (code_ff == $past(lnk_code_ff));
  endproperty
  a_done_sets_flag: assert property (p_done_sets_flag) else $error("done lost"); // [R5]

  property p_status_layout;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    ##1 (STATUS_O[2] == 1'b0) && (STATUS_O[1:0] == presc_ff);
  endproperty
  a_status_layout: assert property (p_status_layout) else $error("status layout"); // [R19]
endmodule : twm_master_tx
`default_nettype wire

// *** verification/twm_slave_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// behavioural bus slave, open drain, pulled-up lines
// ****************************************
module twm_slave_model
(
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic ack_en_i,
  input wire logic [15:0] stretch_ns_i,
  output logic scl_oe_o,
  output logic sda_oe_o,
  output logic [7:0] rx_byte_o,
  output int n_stop_o
);
  int bit_cnt = 0;
  logic [7:0] shreg = 8'h00;
  initial
  begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
    rx_byte_o = 8'h00;
    n_stop_o = 0;
  end
  // start condition restarts the bit count
  always @(negedge sda_i)
    if (scl_i === 1'b1)
      bit_cnt = 0;
  always @(posedge sda_i)
    if (scl_i === 1'b1)
      n_stop_o = n_stop_o + 1;
  always @(posedge scl_i)
    if (bit_cnt < 8)
    begin
      shreg = {shreg[6:0], sda_i};
      bit_cnt = bit_cnt + 1;
    end
  always @(negedge scl_i)
  begin
    if (bit_cnt == 8)
    begin
      rx_byte_o = shreg;
      sda_oe_o = ack_en_i;
      bit_cnt = 9;
      if (stretch_ns_i != 16'h0000)
      begin
        scl_oe_o = 1'b1;
        #(stretch_ns_i);
        scl_oe_o = 1'b0;
      end
    end
    else if (bit_cnt == 9)
    begin
      sda_oe_o = 1'b0;
      bit_cnt = 0;
    end
  end
endmodule : twm_slave_model
`default_nettype wire

// *** verification/test_two_wire_master_transmit_handshake.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) check_val(32'(a), 32'(b))
module test_two_wire_master_transmit_handshake;
  import twm_pkg::*;
  logic clk = 1'b0, link_clk = 1'b0, rst = 1'b1;
  logic ctrl_wr = 1'b0, ctrl_flag = 1'b0, ctrl_start = 1'b0, ctrl_stop = 1'b0;
  logic ctrl_en = 1'b1, data_wr = 1'b0, presc_wr = 1'b0, tb_sda_oe = 1'b0;
  logic [7:0] data_in = 8'h00;
  logic [1:0] presc = 2'h0;
  logic ready, done, start_req, stop_req, scl_o, scl_oe, sda_o, sda_oe;
  logic [7:0] status, dout, slv_byte;
  logic slv_scl_oe, slv_sda_oe, slv_ack = 1'b1;
  logic [15:0] slv_stretch = 16'h0000;
  wire logic scl_w;
  wire logic sda_w;
  int slv_stops, n_mismatch = 0, samples_checked = 0;
  logic [4:0] exp_q[$];
  logic [4:0] exp_code;
  logic done_seen = 1'b0;
  assign scl_w = ~(scl_oe | slv_scl_oe);
  assign sda_w = ~(sda_oe | slv_sda_oe | tb_sda_oe);
  always #50 clk = ~clk;
  initial
  begin
    #17;
    forever
    begin
      #62 link_clk = 1'b1;
      #63 link_clk = 1'b0;
    end
  end
  twm_master_tx uut (.CLK_I(clk), .SYS_RST_I(rst), .CTRL_WR_I(ctrl_wr),
    .CTRL_FLAG_I(ctrl_flag), .CTRL_START_I(ctrl_start), .CTRL_STOP_I(ctrl_stop),
    .CTRL_EN_I(ctrl_en), .CTRL_READY_O(ready), .DATA_WR_I(data_wr), .DATA_I(data_in),
    .PRESC_WR_I(presc_wr), .PRESC_I(presc), .DONE_FLAG_O(done), .START_REQ_O(start_req),
    .STOP_REQ_O(stop_req), .STATUS_O(status), .DATA_O(dout), .LINK_CLK_I(link_clk),
    .SCL_I(scl_w), .SCL_O(scl_o), .SCL_OE_O(scl_oe), .SDA_I(sda_w), .SDA_O(sda_o),
    .SDA_OE_O(sda_oe));
  twm_slave_model slave (.scl_i(scl_w), .sda_i(sda_w), .ack_en_i(slv_ack),
    .stretch_ns_i(slv_stretch), .scl_oe_o(slv_scl_oe), .sda_oe_o(slv_sda_oe),
    .rx_byte_o(slv_byte), .n_stop_o(slv_stops));
  // ****************************************
  // compare, verdict and bounded waits
  // ****************************************
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val
  task automatic complete_run();
    $display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic wait_until(ref logic sig, input logic lvl);
    int n;
    n = 0;
    while (sig !== lvl && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 3000)
    begin
      n_mismatch++;
      $display("BAD t=%0t timeout got=%h exp=%h", $time, sig, lvl);
      complete_run();
    end
  endtask : wait_until
  // ****************************************
  // software side of the handshake
  // ****************************************
  task automatic ctrl_write(input logic flag, input logic sta, input logic sto);
    @(negedge clk);
    {ctrl_wr, ctrl_flag, ctrl_start, ctrl_stop} = {1'b1, flag, sta, sto};
    @(negedge clk);
    ctrl_wr = 1'b0;
    `CHK(start_req, sta);
    if (flag)
      `CHK(done, 1'b0);
  endtask : ctrl_write
  task automatic data_write(input logic [7:0] b);
    @(negedge clk);
    data_wr = 1'b1;
    data_in = b;
    @(negedge clk);
    data_wr = 1'b0;
    `CHK(dout, b);
  endtask : data_write
  task automatic do_op(input logic sta, input logic [4:0] code);
    exp_q.push_back(code);
    ctrl_write(1'b1, sta, 1'b0);
    wait_until(done, 1'b1);
    repeat (5) @(negedge clk);
    `CHK(scl_w, 1'b0);
  endtask : do_op
  task automatic stop_op();
    int n;
    n = slv_stops;
    ctrl_write(1'b1, 1'b0, 1'b1);
    wait_until(stop_req, 1'b0);
    repeat (20) @(negedge clk);
    `CHK(done, 1'b0);
    `CHK(status, {SC_NO_INFO, 1'b0, presc});
    `CHK(slv_stops, n + 1);
    `CHK({scl_o, sda_o}, 2'h0);
  endtask : stop_op
  // ****************************************
  // flag rise: oldest expected code
  // ****************************************
  always @(negedge clk)
  begin
    if (done === 1'b1 && !done_seen)
    begin
      if (exp_q.size() == 0)
        `CHK(status, 8'h00);
      else
      begin
        exp_code = exp_q.pop_front();
        `CHK(status & STATUS_MASK, {exp_code, 3'h0});
        `CHK(status[2:0], {1'b0, presc});
      end
    end
    done_seen = (done === 1'b1);
  end
  initial
  begin
    void'($urandom(32'hec8ab7ca));
    repeat (5) @(negedge clk);
    rst = 1'b0;
    `CHK(done, 1'b0);
    `CHK(status, 8'hf8);
    `CHK(dout, DATA_RST);
    `CHK(ready, 1'b1);
    presc = 2'($urandom_range(3, 0));
    presc_wr = 1'b1;
    @(negedge clk);
    presc_wr = 1'b0;
    // foreign master holds the bus: start waits for its stop
    tb_sda_oe = 1'b1;
    repeat (10) @(negedge clk);
    exp_q.push_back(SC_START);
    ctrl_write(1'b1, 1'b1, 1'b0);
    repeat (60) @(negedge clk);
    `CHK(done, 1'b0);
    tb_sda_oe = 1'b0;
    wait_until(done, 1'b1);
    // write without the flag bit starts nothing
    ctrl_write(1'b0, 1'b1, 1'b0);
    repeat (40) @(negedge clk);
    `CHK(done, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      if (i > 0)
        do_op(1'b1, SC_START);
      slv_stretch = (i == 2) ? 16'd400 : 16'd0;
      slv_ack = (i != 1);
      data_write({7'($urandom), 1'b0});
      do_op(1'b0, slv_ack ? SC_ADDR_ACK : SC_ADDR_NACK);
      `CHK(slv_byte, data_in);
      if (slv_ack)
      begin
        slv_ack = (i == 0);
        data_write(8'($urandom));
        do_op(1'b0, slv_ack ? SC_DATA_ACK : SC_DATA_NACK);
        `CHK(slv_byte, data_in);
      end
      if (i == 0)
        do_op(1'b1, SC_RSTART);
      stop_op();
    end
    complete_run();
  end
endmodule : test_two_wire_master_transmit_handshake
`default_nettype wire
